// file: design/dwd_pkg.sv
/*
  Shared constants for the DAC word and channel decoder.
  Assumes a single 250 MHz clock domain and no register bus.
*/
package dwd_pkg;
  localparam int DWD_DATA_W = 14; // Data word width
  localparam int DWD_ADDR_W = 8; // Address width
  localparam int DWD_GROUPS = 4; // Channel groups
  localparam int DWD_PER_GROUP = 10; // Registers per group
  localparam int DWD_CHANNELS = 40; // Total channels
  localparam int DWD_CH_W = 6; // Channel index width
  localparam int DWD_GAIN_W = 13; // Gain code width
  localparam int DWD_STEP_W = 7; // Step magnitude width
  localparam int DWD_DIR_BIT = 8; // Position of step_direction_bit
  localparam int DWD_ZERO_BIT = 7; // Bit that must be zero in a step word
  localparam int DWD_GRP_LSB = 4; // Group mask low bit
  // Destination select codes {dest_select_high, dest_select_low}
  localparam logic [1:0] DWD_SEL_INPUT = 2'h3;
  localparam logic [1:0] DWD_SEL_OFFSET = 2'h2;
  localparam logic [1:0] DWD_SEL_GAIN = 2'h1;
  localparam logic [1:0] DWD_SEL_SPECIAL = 2'h0;
  localparam logic [13:0] DWD_SOFT_RESET = 14'h3fff; // Soft reset pattern
  localparam logic [13:0] DWD_CODE_MAX = 14'h3fff; // Full-scale input code
  localparam logic [13:0] DWD_CODE_RST = 14'h0000; // Input code reset value
  localparam logic [13:0] DWD_OFFSET_RST = 14'h2000; // Offset reset: zero LSB
  localparam logic [12:0] DWD_GAIN_RST = 13'h1fff; // Gain reset: unity
  localparam logic [3:0] DWD_IDX_MAX = 4'h9; // Highest register index
  typedef enum logic [1:0] {
    DWD_ST_IDLE = 2'b00,
    DWD_ST_STEP = 2'b01
  } dwd_state_e;
endpackage

// file: design/dwd_regfile.sv
/*
  Per-channel storage: input code, offset and gain for each channel.
  Assumes one write channel mask per cycle; read data comes from a register.
*/
`timescale 1ns/10ps
module dwd_regfile
  import dwd_pkg::*;
#(
  parameter int CHANNELS = DWD_CHANNELS
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [CHANNELS-1:0] code_we_i,
  input wire logic [CHANNELS-1:0] offset_we_i,
  input wire logic [CHANNELS-1:0] gain_we_i,
  input wire logic clear_i,
  input wire logic [DWD_DATA_W-1:0] code_wdata_i,
  input wire logic [DWD_DATA_W-1:0] wdata_i,
  input wire logic [DWD_CH_W-1:0] rd_ch_i,
  output logic [DWD_DATA_W-1:0] rd_code_o,
  output logic [CHANNELS*DWD_DATA_W-1:0] code_flat_o,
  output logic [CHANNELS*DWD_DATA_W-1:0] offset_flat_o,
  output logic [CHANNELS*DWD_GAIN_W-1:0] gain_flat_o
);
  logic [DWD_DATA_W-1:0] code_mem [CHANNELS]; // Input codes
  logic [DWD_DATA_W-1:0] offset_mem [CHANNELS]; // Offsets
  logic [DWD_GAIN_W-1:0] gain_mem [CHANNELS]; // Gains

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_ch
      // Each channel stores on its own strobe; clear only hits the code
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          code_mem[g] <= DWD_CODE_RST;
          offset_mem[g] <= DWD_OFFSET_RST;
          gain_mem[g] <= DWD_GAIN_RST;
        end
        else
        begin
          if (clear_i)
            code_mem[g] <= DWD_CODE_RST;
          else if (code_we_i[g])
            code_mem[g] <= code_wdata_i;
          if (offset_we_i[g])
            offset_mem[g] <= wdata_i;
          if (gain_we_i[g])
            gain_mem[g] <= wdata_i[DWD_GAIN_W:1];
        end
      end
      assign code_flat_o[g*DWD_DATA_W +: DWD_DATA_W] = code_mem[g];
      assign offset_flat_o[g*DWD_DATA_W +: DWD_DATA_W] = offset_mem[g];
      assign gain_flat_o[g*DWD_GAIN_W +: DWD_GAIN_W] = gain_mem[g];
    end
  endgenerate

  // Registered read port used by the step engine
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rd_code_o <= DWD_CODE_RST;
    else
      rd_code_o <= code_mem[rd_ch_i];
  end
endmodule // dwd_regfile

// file: design/dwd_decode.sv
/*
  DAC word and channel decoder: routes each write to input code, offset,
  gain or the special function word, and decodes group and index fields.
  Assumes write_i is a one-cycle strobe synchronous to clk_i from the
  host-facing write port, held off while busy_o is high.
*/
//
// Contract
// - Two select bits route data to destination
// - Offset word is offset binary LSBs
// - Gain is unsigned code plus one over 8192
// - Step word: zeros, direction, zero, magnitude
// - Zero magnitude leaves input code unchanged
// - Direction bit set increments, clear decrements
// - Step result saturates at full or zero
// - All-ones special word performs soft reset
// - Every write carries an eight-bit address
// - Upper nibble is group mask; zero means all
// - All-channel writes ignore lower address bits
// - Outputs start cleared to tester ground
`timescale 1ns/10ps
module dwd_decode
  import dwd_pkg::*;
#(
  parameter int GROUPS = DWD_GROUPS,
  parameter int PER_GROUP = DWD_PER_GROUP
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic write_i,
  input wire logic dest_select_high_i,
  input wire logic dest_select_low_i,
  input wire logic [DWD_ADDR_W-1:0] addr_i,
  input wire logic [DWD_DATA_W-1:0] data_i,
  output logic busy_o,
  output logic output_clear_o,
  output logic [GROUPS*PER_GROUP*DWD_DATA_W-1:0] input_code_register_o,
  output logic [GROUPS*PER_GROUP*DWD_DATA_W-1:0] offset_o,
  output logic [GROUPS*PER_GROUP*DWD_GAIN_W-1:0] gain_o
);
  localparam int CH = GROUPS * PER_GROUP; // Channel count

  // Channel mask for a group/index address
  function automatic logic [CH-1:0] chan_mask(input logic [DWD_ADDR_W-1:0] a);
    logic [CH-1:0] m;
    m = '0;
    for (int gi = 0; gi < GROUPS; gi++)
    begin
      for (int ri = 0; ri < PER_GROUP; ri++)
      begin
        if (a[DWD_ADDR_W-1:DWD_GRP_LSB] == 4'h0)
          m[gi*PER_GROUP+ri] = 1'b1;
        else if (a[DWD_GRP_LSB+gi] && a[3:0] == 4'(ri))
          m[gi*PER_GROUP+ri] = 1'b1;
      end
    end
    return m;
  endfunction

  wire [1:0] dest_sel = {dest_select_high_i, dest_select_low_i};
  wire all_sel = (addr_i[DWD_ADDR_W-1:DWD_GRP_LSB] == 4'h0);
  wire idx_ok = all_sel || (addr_i[3:0] <= DWD_IDX_MAX);
  wire take = write_i && !busy_o && idx_ok;
  wire [CH-1:0] wr_mask = chan_mask(addr_i);
  wire is_reset = (dest_sel == DWD_SEL_SPECIAL) && (data_i == DWD_SOFT_RESET);
  // Step word: top five bits and bit 7 zero
  wire is_step = (dest_sel == DWD_SEL_SPECIAL) && (data_i[13:9] == 5'h00)
               && !data_i[DWD_ZERO_BIT];
  wire is_zero_step = (data_i[DWD_STEP_W-1:0] == 7'h00);

  dwd_state_e state; // Step engine state
  dwd_state_e next_state;
  logic [CH-1:0] step_mask; // Channels still to step
  logic step_up; // Latched direction
  logic [DWD_STEP_W-1:0] step_mag; // Latched magnitude
  logic [DWD_CH_W-1:0] step_ch; // Channel being read
  logic step_rd_valid; // Read data matches step_ch
  logic clear_q; // Output clear level
  logic [DWD_DATA_W-1:0] rd_code;
  logic [DWD_DATA_W-1:0] stepped; // Saturated result

  // Lowest set bit of the pending mask picks the next channel
  function automatic logic [DWD_CH_W-1:0] first_ch(input logic [CH-1:0] m);
    logic [DWD_CH_W-1:0] c;
    c = '0;
    for (int i = CH - 1; i >= 0; i--)
      if (m[i])
        c = DWD_CH_W'(i);
    return c;
  endfunction

  wire [DWD_CH_W-1:0] next_ch = first_ch(step_mask);
  // Saturating add and subtract, widened by one bit for overflow
  wire [DWD_DATA_W:0] sum = {1'b0, rd_code} + {8'h00, step_mag};
  wire [DWD_DATA_W:0] diff = {1'b0, rd_code} - {8'h00, step_mag};
  assign stepped = step_up ? (sum[DWD_DATA_W] ? DWD_CODE_MAX : sum[DWD_DATA_W-1:0])
                           : (diff[DWD_DATA_W] ? DWD_CODE_RST : diff[DWD_DATA_W-1:0]);
  wire step_wr = (state == DWD_ST_STEP) && step_rd_valid; // Commit one channel
  wire [CH-1:0] step_bit = CH'(1) << step_ch;

  // Direct writes land in one cycle; the step path writes one channel at a time
  wire [CH-1:0] code_we = step_wr ? step_bit
                        : ((take && dest_sel == DWD_SEL_INPUT) ? wr_mask : '0);
  wire [DWD_DATA_W-1:0] code_wd = step_wr ? stepped : data_i;
  wire [CH-1:0] offset_we = (take && dest_sel == DWD_SEL_OFFSET) ? wr_mask : '0;
  wire [CH-1:0] gain_we = (take && dest_sel == DWD_SEL_GAIN) ? wr_mask : '0;
  wire start_step = take && is_step && !is_zero_step;
  wire soft_clear = take && is_reset;

  dwd_regfile #(.CHANNELS(CH)) u_regs (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .code_we_i(code_we),
    .offset_we_i(offset_we),
    .gain_we_i(gain_we),
    .clear_i(soft_clear),
    .code_wdata_i(code_wd),
    .wdata_i(data_i),
    .rd_ch_i(next_ch),
    .rd_code_o(rd_code),
    .code_flat_o(input_code_register_o),
    .offset_flat_o(offset_o),
    .gain_flat_o(gain_o)
  );

  // Step engine sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      DWD_ST_IDLE: if (start_step) next_state = DWD_ST_STEP;
      DWD_ST_STEP: if (step_wr && step_mask == '0) next_state = DWD_ST_IDLE;
    endcase
  end

  // Step bookkeeping: read address presented one cycle before commit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= DWD_ST_IDLE;
      step_mask <= '0;
      step_up <= 1'b0;
      step_mag <= '0;
      step_ch <= '0;
      step_rd_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (start_step)
      begin
        step_mask <= wr_mask;
        step_up <= data_i[DWD_DIR_BIT];
        step_mag <= data_i[DWD_STEP_W-1:0];
        step_rd_valid <= 1'b0;
      end
      else if (state == DWD_ST_STEP && !step_rd_valid)
      begin
        step_ch <= next_ch;
        step_mask <= step_mask & ~(CH'(1) << next_ch);
        step_rd_valid <= 1'b1;
      end
      else
        step_rd_valid <= 1'b0;
    end
  end

  // Clear holds from power-up until the first input code write or step
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      clear_q <= 1'b1;
    else if (take && is_reset)
      clear_q <= 1'b1;
    else if (|code_we)
      clear_q <= 1'b0;
  end

  assign busy_o = (state != DWD_ST_IDLE);
  assign output_clear_o = clear_q;

  // Offset decode sanity: a stored word keeps its offset-binary value
  property p_offset_store;
    @(posedge clk_i) disable iff (!rst_b_i)
    (take && dest_sel == DWD_SEL_OFFSET && all_sel) |=> (offset_o[DWD_DATA_W-1:0] == $past(data_i));
  endproperty
  a_offset_store: assert property (p_offset_store) else $error("offset not stored");

  property p_gain_store;
    @(posedge clk_i) disable iff (!rst_b_i)
    (take && dest_sel == DWD_SEL_GAIN && all_sel) |=> (gain_o[DWD_GAIN_W-1:0] == $past(data_i[DWD_GAIN_W:1]));
  endproperty
  a_gain_store: assert property (p_gain_store) else $error("gain not stored");

  property p_bad_index;
    @(posedge clk_i) disable iff (!rst_b_i)
    // Idle only: a step commit may legally drive code_we while a refused write arrives
    (write_i && !busy_o && !all_sel && addr_i[3:0] > DWD_IDX_MAX)
      |-> (code_we == '0 && offset_we == '0 && gain_we == '0);
  endproperty
  a_bad_index: assert property (p_bad_index) else $error("bad index wrote");

  property p_zero_step;
    @(posedge clk_i) disable iff (!rst_b_i)
    (take && is_step && is_zero_step) |=> !busy_o;
  endproperty
  a_zero_step: assert property (p_zero_step) else $error("zero step started");

  sequence s_step_begin;
    take && is_step && !is_zero_step;
  endsequence
  property p_step_busy;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_step_begin |=> busy_o ##[1:200] !busy_o;
  endproperty
  a_step_busy: assert property (p_step_busy) else $error("step never ends");

  property p_saturate;
    @(posedge clk_i) disable iff (!rst_b_i)
    (step_wr && step_up && sum[DWD_DATA_W]) |-> (code_wd == DWD_CODE_MAX);
  endproperty
  a_saturate: assert property (p_saturate) else $error("no saturation");

  // Decrement below zero clamps at zero scale instead of wrapping
  property p_floor;
    @(posedge clk_i) disable iff (!rst_b_i)
    (step_wr && !step_up && diff[DWD_DATA_W]) |-> (code_wd == DWD_CODE_RST);
  endproperty
  a_floor: assert property (p_floor) else $error("no floor clamp");

  property p_soft_reset;
    @(posedge clk_i) disable iff (!rst_b_i)
    (take && is_reset) |=> (output_clear_o && input_code_register_o[DWD_DATA_W-1:0] == DWD_CODE_RST);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

  property p_all_groups;
    @(posedge clk_i) disable iff (!rst_b_i)
    (take && all_sel && dest_sel == DWD_SEL_INPUT) |-> (&code_we);
  endproperty
  a_all_groups: assert property (p_all_groups) else $error("all-select incomplete");
endmodule // dwd_decode

// file: testbench/dwd_host.sv
/*
  Host model that issues write commands to the word and channel decoder.
  Assumes the decoder samples the write port on the rising edge of clk_i.
*/
`timescale 1ns/10ps
module dwd_host
  import dwd_pkg::*;
(
  input wire logic clk_i,
  input wire logic busy_i,
  output logic write_o,
  output logic sel_high_o,
  output logic sel_low_o,
  output logic [DWD_ADDR_W-1:0] addr_o,
  output logic [DWD_DATA_W-1:0] data_o,
  output logic timeout_o
);
  // Idle lines start defined so nothing floats at time zero
  initial
  begin
    write_o = 1'b0;
    {sel_high_o, sel_low_o} = 2'h0;
    addr_o = 8'h00;
    data_o = 14'h0000;
    timeout_o = 1'b0;
  end

  // Bounded wait for the decoder to go idle; writes while busy would be lost
  task automatic wait_idle();
    int n;
    begin
      n = 0;
      while (busy_i !== 1'b0 && n < 400)
      begin
        @(posedge clk_i);
        #1;
        n++;
      end
      if (n == 400)
        timeout_o = 1'b1;
    end
  endtask

  // One whole command: select, eight-bit address and data held for one edge
  task automatic send(input logic [1:0] sel, input logic [7:0] addr, input logic [13:0] data);
    begin
      @(posedge clk_i);
      #1;
      wait_idle();
      write_o = 1'b1;
      {sel_high_o, sel_low_o} = sel;
      addr_o = addr;
      data_o = data;
      @(posedge clk_i);
      #1;
      // Released lines show the inverse so stale values cannot pass
      write_o = 1'b0;
      {sel_high_o, sel_low_o} = ~sel;
      addr_o = ~addr;
      data_o = ~data;
      @(posedge clk_i);
      #1;
      wait_idle();
    end
  endtask
endmodule // dwd_host

// file: testbench/dwd_decode_tb.sv
/*
  Self-checking bench for the word and channel decoder.
  Assumes the host model in dwd_host and the assertions inside the design.
*/
`timescale 1ns/10ps
module dwd_decode_tb
  import dwd_pkg::*;
;
  typedef struct packed {int kind; int ch; logic [13:0] val;} dwd_note_s;
  logic clk = 1'b0; // 250 MHz
  logic rst_b = 1'b0;
  logic write, sel_h, sel_l, busy, clear, host_timeout;
  logic [7:0] addr;
  logic [13:0] data, d;
  logic [559:0] code, offset;
  logic [519:0] gain;
  logic [31:0] seed = 32'h8165_9eea;
  dwd_note_s notes[$];
  event probe;
  int errors = 0;
  int n_checks = 0;

  always #2 clk = ~clk;

  dwd_host host_u (.clk_i(clk), .busy_i(busy), .write_o(write), .sel_high_o(sel_h), .sel_low_o(sel_l),
    .addr_o(addr), .data_o(data), .timeout_o(host_timeout));

  dwd_decode dut_u (.clk_i(clk), .rst_b_i(rst_b), .write_i(write), .dest_select_high_i(sel_h),
    .dest_select_low_i(sel_l), .addr_i(addr), .data_i(data), .busy_o(busy), .output_clear_o(clear),
    .input_code_register_o(code), .offset_o(offset), .gain_o(gain));

  // Random data words from a fixed-seed shift register
  function automatic logic [13:0] rnd();
    seed = seed[0] ? ((seed >> 1) ^ 32'h8020_0003) : (seed >> 1);
    return seed[13:0];
  endfunction

  task automatic note(input int kind, input int ch, input logic [13:0] val);
    notes.push_back('{kind, ch, val});
  endtask

  task automatic cmp_word(input string what, input int ch, input logic [13:0] exp, input logic [13:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0s ch %0d expected %h seen %h", what, ch, exp, got);
    end
  endtask

  // Single-bit status outputs
  task automatic cmp_flag(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check(input string name);
    -> probe;
    #1;
    $display("test %0s done", name);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watcher: takes every queued note, oldest first, and compares it with what the outputs show
  always @(probe)
  begin
    while (notes.size() > 0)
    begin
      dwd_note_s n;
      n = notes.pop_front();
      case (n.kind)
        0: cmp_word("code", n.ch, n.val, code[n.ch*14+:14]);
        1: cmp_word("offset", n.ch, n.val, offset[n.ch*14+:14]);
        2: cmp_word("gain", n.ch, n.val, {1'b0, gain[n.ch*13+:13]});
        3: cmp_flag("clear", n.val[0], clear);
        default: cmp_flag("busy", n.val[0], busy);
      endcase
    end
  end

  // A stuck busy flag ends the run as a failure
  always @(posedge host_timeout)
  begin
    errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    note(0, 0, 14'h0000); note(0, 39, 14'h0000); note(1, 5, 14'h2000); note(2, 5, 14'h1fff);
    note(3, 0, 14'h0001); check("reset");
    d = rnd(); host_u.send(2'h3, 8'h13, d); note(0, 3, d); note(3, 0, 14'h0000);
    d = rnd(); host_u.send(2'h2, 8'h25, d); note(1, 15, d);
    d = rnd(); host_u.send(2'h1, 8'h25, d); note(2, 15, {1'b0, d[13:1]}); check("route");
    d = rnd(); host_u.send(2'h3, 8'ha7, d); note(0, 17, d); note(0, 37, d); note(0, 27, 14'h0000);
    check("groups");
    d = (rnd() & 14'h1fff) | 14'h0001; host_u.send(2'h3, 8'h0f, d);
    for (int i = 0; i < 40; i++) note(0, i, d);
    host_u.send(2'h3, 8'h1a, ~d); note(0, 9, d); check("all channels");
    host_u.send(2'h3, 8'h10, 14'h3ffa); host_u.send(2'h0, 8'h10, 14'h0107); note(0, 0, 14'h3fff);
    host_u.send(2'h0, 8'h10, 14'h0100); note(0, 0, 14'h3fff); check("step up");
    // Channel 0 notes are compared only at check, after every command of the test has run
    host_u.send(2'h3, 8'h10, 14'h0005); host_u.send(2'h0, 8'h10, 14'h007f); note(0, 0, 14'h0000);
    check("step floor");
    host_u.send(2'h3, 8'h10, 14'h0100); host_u.send(2'h0, 8'h10, 14'h0007); note(0, 0, 14'h00f9);
    check("step down");
    host_u.send(2'h0, 8'h30, 14'h0101); note(0, 0, 14'h00fa); note(0, 10, d + 14'h0001);
    // Bit 7 set: not a step word, so the code must not move
    host_u.send(2'h0, 8'h10, 14'h0185); note(0, 0, 14'h00fa); check("step groups");
    host_u.send(2'h0, 8'h00, 14'h3fff); note(0, 10, 14'h0000); note(0, 39, 14'h0000);
    note(3, 0, 14'h0001); check("soft reset");
    host_u.send(2'h2, 8'h15, 14'h0abc); note(1, 5, 14'h0abc); check("offset");
    // Mid-run reset must bring back every power-up value
    @(posedge clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    note(1, 5, 14'h2000); note(2, 15, 14'h1fff); note(3, 0, 14'h0001); note(4, 0, 14'h0000);
    check("mid reset");
    report_and_stop();
  end
endmodule // dwd_decode_tb
